// [hdl/sbm_top.v]
// The APB slave port and the placing of the registers were chosen for this implementation.
`include "sbm_regs.vh"
`default_nettype none
module sbm_top (
    input  wire        core_clk_i,  // Core clock 200 MHz
    input  wire        sys_rst_i,   // Sync reset, high
    input  wire        ce_i,        // Clock enable
    input  wire        psel_i,      // APB select
    input  wire        penable_i,   // APB enable
    input  wire        pwrite_i,    // APB write
    input  wire [11:0] paddr_i,     // APB address
    input  wire [31:0] pwdata_i,    // APB write data
    output reg  [31:0] prdata_o,    // APB read data
    output reg         pready_o,    // APB ready
    output reg         pslverr_o,   // APB error
    input  wire        scl_i,       // Clock line level
    output reg         scl_o,       // Clock line out, always 0
    output reg         scl_oe_n_o,  // Low pulls clock line low
    input  wire        sda_i,       // Data line level
    output reg         sda_o,       // Data line out, always 0
    output reg         sda_oe_n_o,  // Low pulls data line low
    output reg         irq_o        // Level interrupt
);
    // -----------------------------------------------------------
    // States
    // -----------------------------------------------------------
    localparam ST_IDLE  = 3'h0;
    localparam ST_START = 3'h1;
    localparam ST_RSTRT = 3'h2;
    localparam ST_STOP  = 3'h3;
    localparam ST_XFER  = 3'h4;
    localparam ST_ACK   = 3'h5;

    // -----------------------------------------------------------
    // Registers
    // -----------------------------------------------------------
    reg  [15:0] ctrl;
    reg  [15:0] qtr;
    reg  [7:0]  tx_data;
    reg  [7:0]  rx_data;
    reg  [7:0]  shift;
    reg         tx_buffer_full, rx_buffer_full, rxov, wcol, bus_collision_flag, txstat, ack_received_status;
    reg         start_seen, stop_seen;
    reg  [4:0]  irq_stat;
    reg  [4:0]  irq_mask;
    reg  [2:0]  state;
    reg  [1:0]  phase;
    reg  [3:0]  bitcnt;
    reg         is_tx, ack_bit;
    reg  [1:0]  scl_sync, sda_sync;
    reg         sda_d;
    wire        tick;

    sbm_quarter_timer u_timer (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .ce_i       (ce_i),
        .run_i      (state != ST_IDLE),
        .reload_i   (qtr),
        .tick_o     (tick)
    );

    // -----------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------
    function sel_reg;
        input [11:0] a;
        input [11:0] off;
        begin
            sel_reg = (a == off);
        end
    endfunction

    wire acc   = psel_i & penable_i & ~pready_o;
    wire wr    = acc & pwrite_i;
    wire rd    = acc & ~pwrite_i;
    wire scl_s = scl_sync[1];
    wire sda_s = sda_sync[1];
    wire busy  = (state != ST_IDLE);
    wire w_ctl = wr & sel_reg(paddr_i, `SBM_CTRL_OFF);
    wire w_tx  = wr & sel_reg(paddr_i, `SBM_TX_OFF);
    wire w_st  = wr & sel_reg(paddr_i, `SBM_STAT_OFF);
    wire w_is  = wr & sel_reg(paddr_i, `SBM_IRQ_STAT_OFF);
    wire r_rx  = rd & sel_reg(paddr_i, `SBM_RX_OFF);
    wire mapped = sel_reg(paddr_i, `SBM_CTRL_OFF)
                | sel_reg(paddr_i, `SBM_STAT_OFF)
                | sel_reg(paddr_i, `SBM_TX_OFF)
                | sel_reg(paddr_i, `SBM_RX_OFF)
                | sel_reg(paddr_i, `SBM_IRQ_STAT_OFF)
                | sel_reg(paddr_i, `SBM_IRQ_MASK_OFF)
                | sel_reg(paddr_i, `SBM_QTR_OFF);
    wire enabled = ctrl[`SBM_C_ENABLE];
    // Busy transmit write is refused
    wire tx_busy = busy | tx_buffer_full | (|ctrl[4:0]);
    wire tx_ok   = w_tx & ~tx_busy;
    wire tx_bad  = w_tx & tx_busy;
    // Collision: released data bit reads low, ack slot excluded
    wire coll    = (state == ST_XFER) & is_tx & phase[1] & sda_oe_n_o
                 & ~sda_s & tick & (bitcnt != 4'h8);
    wire done    = tick & (phase == 2'h3) & (state != ST_IDLE)
                 & (state != ST_XFER | bitcnt == 4'h8);

    // -----------------------------------------------------------
    // Input synchronisers
    // -----------------------------------------------------------
    always @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            sda_d    <= 1'b1;
        end else if (ce_i) begin
            scl_sync <= {scl_sync[0], scl_i};
            sda_sync <= {sda_sync[0], sda_i};
            sda_d    <= sda_sync[1]; // Last data level, for edges
        end
    end

    // -----------------------------------------------------------
    // APB answer, one wait state
    // -----------------------------------------------------------
    always @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h00000000;
        end else if (ce_i) begin
            pready_o  <= acc;
            pslverr_o <= acc & ~mapped;
            prdata_o  <= 32'h00000000;
            if (rd) begin
                case (paddr_i)
                    `SBM_CTRL_OFF:     prdata_o <= {16'h0000, ctrl};
                    `SBM_STAT_OFF:     prdata_o <= {16'h0000, ack_received_status,
                        txstat, 3'h0, bus_collision_flag, 2'h0, wcol, rxov, 1'b0,
                        stop_seen, start_seen, 1'b0, rx_buffer_full, tx_buffer_full};
                    `SBM_RX_OFF:       prdata_o <= {24'h000000, rx_data};
                    `SBM_IRQ_STAT_OFF: prdata_o <= {27'h0, irq_stat};
                    `SBM_IRQ_MASK_OFF: prdata_o <= {27'h0, irq_mask};
                    `SBM_QTR_OFF:      prdata_o <= {16'h0000, qtr};
                    default:           prdata_o <= 32'h00000000;
                endcase
            end
        end
    end

    // -----------------------------------------------------------
    // Control register and sequencer
    // -----------------------------------------------------------
    always @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            ctrl       <= `SBM_CTRL_RST;
            qtr        <= `SBM_QTR_DEF;
            state      <= ST_IDLE;
            phase      <= 2'h0;
            bitcnt     <= 4'h0;
            is_tx      <= 1'b0;
            ack_bit    <= 1'b1;
            shift      <= 8'h00;
            tx_data    <= 8'h00;
            tx_buffer_full        <= 1'b0;
            txstat     <= 1'b0;
            ack_received_status    <= 1'b0;
            scl_oe_n_o <= 1'b1;
            sda_oe_n_o <= 1'b1;
        end else if (ce_i) begin
            if (w_ctl) begin
                ctrl <= pwdata_i[15:0];
            end
            if (wr & sel_reg(paddr_i, `SBM_QTR_OFF)) begin
                qtr <= pwdata_i[15:0];
            end
            if (tx_ok) begin
                tx_data <= pwdata_i[7:0];
                tx_buffer_full     <= 1'b1;
            end
            if (tick) begin
                phase <= phase + 2'h1;
            end
            case (state)
                ST_IDLE: begin
                    phase <= 2'h0;
                    if (!enabled) begin
                        scl_oe_n_o <= 1'b1;
                        sda_oe_n_o <= 1'b1;
                    end else if (ctrl[`SBM_C_START]) begin
                        state <= ST_START;
                    end else if (ctrl[`SBM_C_RESTART]) begin
                        state <= ST_RSTRT;
                    end else if (ctrl[`SBM_C_STOP]) begin
                        state <= ST_STOP;
                    end else if (ctrl[`SBM_C_RECV]) begin
                        state  <= ST_XFER;
                        is_tx  <= 1'b0;
                        bitcnt <= 4'h0;
                    end else if (ctrl[`SBM_C_ACKSEQ]) begin
                        state   <= ST_ACK;
                        ack_bit <= ctrl[`SBM_C_ACKVAL];
                    end else if (tx_buffer_full) begin
                        state  <= ST_XFER;
                        is_tx  <= 1'b1;
                        bitcnt <= 4'h0;
                        shift  <= tx_data;
                        tx_buffer_full    <= 1'b0;
                        txstat <= 1'b1;
                    end
                end
                ST_START: begin
                    // Both released, data falls, then clock falls
                    if (tick) begin
                        case (phase)
                            2'h0: sda_oe_n_o <= 1'b0;
                            2'h2: scl_oe_n_o <= 1'b0;
                            default: ;
                        endcase
                    end
                end
                ST_RSTRT: begin
                    // Release data, raise clock, then data falls
                    if (tick) begin
                        case (phase)
                            2'h0: sda_oe_n_o <= 1'b1;
                            2'h1: scl_oe_n_o <= 1'b1;
                            2'h2: sda_oe_n_o <= 1'b0;
                            default: scl_oe_n_o <= 1'b0;
                        endcase
                    end
                end
                ST_STOP: begin
                    // Data low, clock rises, then data rises
                    if (tick) begin
                        case (phase)
                            2'h0: sda_oe_n_o <= 1'b0;
                            2'h1: scl_oe_n_o <= 1'b1;
                            2'h2: sda_oe_n_o <= 1'b1;
                            default: ;
                        endcase
                    end
                end
                ST_XFER, ST_ACK: begin
                    // Quarter 0 sets data, 1 and 2 clock high
                    if (tick) begin
                        case (phase)
                            2'h0: begin
                                if (state == ST_ACK) begin
                                    sda_oe_n_o <= ack_bit;
                                end else if (!is_tx | bitcnt == 4'h8) begin
                                    sda_oe_n_o <= 1'b1;
                                end else begin
                                    sda_oe_n_o <= shift[7];
                                end
                            end
                            2'h1: scl_oe_n_o <= 1'b1;
                            2'h2: begin
                                if (state == ST_XFER) begin
                                    if (bitcnt == 4'h8) begin
                                        ack_received_status <= sda_s;
                                    end else begin
                                        shift <= {shift[6:0], sda_s};
                                    end
                                end
                            end
                            default: begin
                                scl_oe_n_o <= 1'b0;
                                bitcnt     <= bitcnt + 4'h1;
                            end
                        endcase
                    end
                    if (state == ST_XFER & !is_tx & bitcnt == 4'h7
                        & tick & phase == 2'h3) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
            if (coll) begin
                state      <= ST_IDLE;
                txstat     <= 1'b0;
                scl_oe_n_o <= 1'b1;
                sda_oe_n_o <= 1'b1;
                ctrl[4:0]  <= 5'h00;
            end else if (done) begin
                state <= ST_IDLE;
                if (state == ST_XFER & is_tx) begin
                    txstat <= 1'b0;
                end
                case (state)
                    ST_START: ctrl[`SBM_C_START]   <= 1'b0;
                    ST_RSTRT: ctrl[`SBM_C_RESTART] <= 1'b0;
                    ST_STOP:  ctrl[`SBM_C_STOP]    <= 1'b0;
                    ST_ACK:   ctrl[`SBM_C_ACKSEQ]  <= 1'b0;
                    default: ;
                endcase
            end else if (state == ST_XFER & !is_tx & bitcnt == 4'h7
                         & tick & phase == 2'h3) begin
                ctrl[`SBM_C_RECV] <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------
    // Receive buffer and sticky flags, set beats clear
    // -----------------------------------------------------------
    wire rx_load = state == ST_XFER & !is_tx & bitcnt == 4'h7
                 & tick & phase == 2'h3;
    always @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            rx_data    <= 8'h00;
            rx_buffer_full        <= 1'b0;
            rxov       <= 1'b0;
            wcol       <= 1'b0;
            bus_collision_flag        <= 1'b0;
            start_seen <= 1'b0;
            stop_seen  <= 1'b0;
            irq_stat   <= `SBM_IRQ_RST;
            irq_mask   <= `SBM_IRQ_RST;
            irq_o      <= 1'b0;
        end else if (ce_i) begin
            if (rx_load & rx_buffer_full) begin
                rxov <= 1'b1;
            end else if (w_st & ~pwdata_i[`SBM_S_RXOV]) begin
                rxov <= 1'b0;
            end
            if (rx_load & ~rx_buffer_full) begin
                rx_data <= shift;
                rx_buffer_full     <= 1'b1;
            end else if (r_rx) begin
                rx_buffer_full <= 1'b0;
            end
            if (tx_bad) begin
                wcol <= 1'b1;
            end else if (w_st & ~pwdata_i[`SBM_S_WCOL]) begin
                wcol <= 1'b0;
            end
            if (coll) begin
                bus_collision_flag <= 1'b1;
            end else if (w_st & ~pwdata_i[`SBM_S_BCL]) begin
                bus_collision_flag <= 1'b0;
            end
            if (sda_d & scl_s & ~sda_s) begin
                start_seen <= 1'b1;
                stop_seen  <= 1'b0;
            end else if (~sda_d & scl_s & sda_s) begin
                start_seen <= 1'b0;
                stop_seen  <= 1'b1;
            end
            if (w_is) begin
                irq_stat <= (irq_stat & ~pwdata_i[4:0]) | {rx_load,
                    rx_load & rx_buffer_full, tx_bad, coll, done};
            end else begin
                irq_stat <= irq_stat | {rx_load, rx_load & rx_buffer_full,
                    tx_bad, coll, done};
            end
            if (wr & sel_reg(paddr_i, `SBM_IRQ_MASK_OFF)) begin
                irq_mask <= pwdata_i[4:0];
            end
            irq_o <= |(irq_stat & irq_mask);
        end
    end

    // Open-drain outputs always drive zero when enabled
    always @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
        end else begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// [include/sbm_regs.vh]
`ifndef SBM_REGS_VH
`define SBM_REGS_VH
// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define SBM_CTRL_OFF      12'h000
`define SBM_STAT_OFF      12'h004
`define SBM_TX_OFF        12'h008
`define SBM_RX_OFF        12'h00C
`define SBM_IRQ_STAT_OFF  12'h010
`define SBM_IRQ_MASK_OFF  12'h014
`define SBM_QTR_OFF       12'h018
// ---------------------------------------------------------------
// Control fields
// ---------------------------------------------------------------
`define SBM_C_START       0
`define SBM_C_RESTART     1
`define SBM_C_STOP        2
`define SBM_C_RECV        3
`define SBM_C_ACKSEQ      4
`define SBM_C_ACKVAL      5
`define SBM_C_ENABLE      15
// ---------------------------------------------------------------
// Status fields
// ---------------------------------------------------------------
`define SBM_S_TBF         0
`define SBM_S_RBF         1
`define SBM_S_START_SEEN  3
`define SBM_S_STOP_SEEN   4
`define SBM_S_RXOV        6
`define SBM_S_WCOL        7
`define SBM_S_BCL         10
`define SBM_S_TXSTAT      14
`define SBM_S_ACK_RECEIVED_STATUS     15
// ---------------------------------------------------------------
// Interrupt event bits
// ---------------------------------------------------------------
`define SBM_I_DONE        0
`define SBM_I_BCL         1
`define SBM_I_WCOL        2
`define SBM_I_RXOV        3
`define SBM_I_RXFULL      4
// ---------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------
`define SBM_CTRL_RST      16'h0000
`define SBM_STAT_RST      16'h0000
`define SBM_IRQ_RST       5'h00
`define SBM_QTR_DEF       16'h007D
`endif

// [hdl/sbm_quarter_timer.v]
`default_nettype none
// ---------------------------------------------------------------
// Quarter bit period tick generator
// ---------------------------------------------------------------
module sbm_quarter_timer (
    input  wire        core_clk_i,  // Core clock
    input  wire        sys_rst_i,   // Sync reset
    input  wire        ce_i,        // Clock enable
    input  wire        run_i,       // Count while high
    input  wire [15:0] reload_i,    // Quarter period minus one, in cycles
    output reg         tick_o       // One cycle pulse
);
    reg [15:0] count;

    // Count down, pulse on zero
    always @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            count  <= 16'h0000;
            tick_o <= 1'b0;
        end else if (ce_i) begin
            tick_o <= 1'b0;
            if (!run_i) begin
                count <= reload_i;
            end else if (count == 16'h0000) begin
                count  <= reload_i;
                tick_o <= 1'b1;
            end else begin
                count <= count - 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// [verif/sbm_monitor.sv]
`default_nettype none
// ----------------------------------
// Port checker
// ----------------------------------
module sbm_monitor (
    input wire logic        core_clk_i, // Clock
    input wire logic        sys_rst_i,  // Reset
    input wire logic        psel_i,     // Select
    input wire logic        penable_i,  // Enable
    input wire logic        pwrite_i,   // Write
    input wire logic [11:0] paddr_i,    // Address
    input wire logic [31:0] pwdata_i,   // Write data
    input wire logic [31:0] prdata_o,   // Read data
    input wire logic        pready_o,   // Ready
    input wire logic        pslverr_o,  // Error
    input wire logic        scl_oe_n_o, // Clock pull
    input wire logic        sda_oe_n_o, // Data pull
    input wire logic        irq_o       // Interrupt
);
    timeunit 1ns;
    timeprecision 1ps;
    // Completed control write with the enable set
    wire ctl_wr = psel_i && penable_i && pready_o && pwrite_i
        && paddr_i == 12'h000 && pwdata_i[15];
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    ready_answer_a: assert property (psel_i && penable_i && !pready_o
        |=> pready_o) else $error("access not answered");
    ready_pulse_a: assert property (pready_o |=> !pready_o)
        else $error("ready held");
    err_ready_a: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    unmapped_err_a: assert property (pready_o && paddr_i > 12'h018
        |-> pslverr_o && (pwrite_i || prdata_o == 32'h0))
        else $error("unmapped access accepted");
    upper_zero_a: assert property (pready_o && !pwrite_i
        |-> prdata_o[31:16] == 16'h0000) else $error("upper bits set");
    reset_idle_a: assert property (disable iff (1'b0) sys_rst_i
        |=> !pready_o && scl_oe_n_o && sda_oe_n_o && !irq_o)
        else $error("reset state wrong");
    clock_high_a: assert property ($rose(scl_oe_n_o)
        |-> scl_oe_n_o [*2]) else $error("clock high too short");
    start_cond_a:
    assert property (ctl_wr && pwdata_i[1:0] != 2'b00
        |-> ##[1:1000] ($fell(sda_oe_n_o) && scl_oe_n_o))
        else $error("no start condition");
    stop_cond_a:
    assert property (ctl_wr && pwdata_i[2:0] == 3'b100
        |-> ##[1:1000] ($rose(sda_oe_n_o) && scl_oe_n_o))
        else $error("no stop condition");
endmodule
bind sbm_top sbm_monitor u_mon (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .scl_oe_n_o(scl_oe_n_o),
    .sda_oe_n_o(sda_oe_n_o), .irq_o(irq_o)
);
`default_nettype wire

// [verif/sbm_bus_device.sv]
`default_nettype none
// ----------------------------------
// Far-side bus device
// ----------------------------------
module sbm_bus_device (
    input  wire logic       core_clk_i, // Sampling clock
    input  wire logic       scl_i,      // Clock line level
    input  wire logic       load_i,     // Load a bit pattern
    input  wire logic [8:0] bits_i,     // Pattern, first bit on top
    output var  logic       sda_oe_n_o  // Low pulls data low
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] sh;
    logic       scl_q;
    // Next bit after each falling clock; released once used up
    always @(posedge core_clk_i) begin
        scl_q <= scl_i;
        if (load_i) begin
            sh <= bits_i;
        end else if (scl_q && !scl_i) begin
            sh <= {sh[7:0], 1'b1};
        end
    end
    assign sda_oe_n_o = sh[8];
endmodule
`default_nettype wire

// [verif/sbm_top_tb.sv]
`default_nettype none
module sbm_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst, ce, psel, penable, pwrite, dev_ld, rerr;
    logic        scl_q, sda_q;
    logic [11:0] paddr;
    logic [31:0] pwdata, rdat, v, r0;
    logic [31:0] seed = 32'h7;
    logic [8:0]  dev_bits, cap;
    wire  [31:0] prdata;
    wire         pready, pslverr, scl_oe_n, sda_oe_n, irq, dev_oe_n;
    wire         scl_w = scl_oe_n;            // Only the master drives
    wire         sda_w = sda_oe_n & dev_oe_n; // Pulled up, wired low
    int          nrise, nst, nsp, k, n, num_errors, check_count;
    // ----------------------------------
    // Clock, design and far side
    // ----------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    sbm_top dut (
        .core_clk_i(clk), .sys_rst_i(rst), .ce_i(ce), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .scl_i(scl_w), .scl_o(),
        .scl_oe_n_o(scl_oe_n), .sda_i(sda_w), .sda_o(),
        .sda_oe_n_o(sda_oe_n), .irq_o(irq)
    );
    sbm_bus_device u_dev (
        .core_clk_i(clk), .scl_i(scl_w), .load_i(dev_ld),
        .bits_i(dev_bits), .sda_oe_n_o(dev_oe_n)
    );
    // Count start and stop conditions, shift data at clock rise
    always @(posedge clk) begin
        scl_q <= scl_w;
        sda_q <= sda_w;
        if (!scl_q && scl_w) begin
            cap   <= {cap[7:0], sda_w};
            nrise <= nrise + 1;
        end
        if (scl_w && scl_q && sda_q && !sda_w) nst <= nst + 1;
        if (scl_w && scl_q && !sda_q && sda_w) nsp <= nsp + 1;
    end
    // ----------------------------------
    // Helpers
    // ----------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] frame(input logic [31:0] b,
                                          input logic a);
        return {23'h0, b[7:0], a};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic fail_wait();
        num_errors++;
        $display("[ERR] %0t wait ran out", $time);
        report_and_stop();
    endtask
    // One APB transfer, held until ready is seen, then one idle edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int i;
        i = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        if (i >= 50) fail_wait();
    endtask
    task automatic poll(input logic [11:0] a, input int b, input logic x);
        int i;
        for (i = 0; i < 400; i++) begin
            apb(1'b0, a, 32'h0);
            if (rdat[b] === x) break;
        end
        if (i >= 400) fail_wait();
    endtask
    task automatic ld(input logic [8:0] p);
        dev_bits <= p;
        dev_ld   <= 1'b1;
        @(posedge clk);
        dev_ld   <= 1'b0;
    endtask
    // ----------------------------------
    // Scenarios
    // ----------------------------------
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        dev_ld = 1'b1;
        dev_bits = 9'h1FF;
        repeat (4) @(posedge clk);
        rst    <= 1'b0;
        dev_ld <= 1'b0;
        @(posedge clk);
        apb(1'b0, 12'h000, 32'h0);
        chk(rdat, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        chk(rdat, 32'h0);
        apb(1'b0, 12'h01C, 32'h0);
        chk({rdat[31:1], rerr}, 32'h1);
        apb(1'b1, 12'h018, 32'h2); // Bit of 12 cycles, 60 ns
        apb(1'b1, 12'h014, 32'h1F);
        apb(1'b1, 12'h000, 32'h8000);
        $display("registers done");
        // Start, then a random byte; a second write while busy
        apb(1'b1, 12'h000, 32'h8001);
        poll(12'h000, 0, 1'b0);
        chk(nst, 1);
        v = xs() & 32'hFF;
        ld(9'h1FE);
        apb(1'b1, 12'h008, v);
        apb(1'b0, 12'h004, 32'h0);
        chk(rdat & 32'h4000, 32'h4000);
        apb(1'b1, 12'h008, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        chk(rdat & 32'h80, 32'h80);
        poll(12'h004, 14, 1'b0);
        chk(rdat & 32'h8000, 32'h0);
        chk({23'h0, cap}, frame(v, 1'b0));
        apb(1'b1, 12'h004, 32'h0);
        $display("transmit done");
        // Restart, two bytes in, the first left unread
        apb(1'b1, 12'h000, 32'h8002);
        poll(12'h000, 1, 1'b0);
        chk(nst, 2);
        for (k = 0; k < 2; k++) begin
            v = xs() & 32'hFF;
            if (k == 0) r0 = v;
            ld({v[7:0], 1'b1});
            apb(1'b1, 12'h000, 32'h8008);
            poll(12'h000, 3, 1'b0);
            chk({24'h0, cap[7:0]}, v);
        end
        apb(1'b0, 12'h004, 32'h0);
        chk(rdat & 32'h42, 32'h42);
        apb(1'b0, 12'h00C, 32'h0);
        chk(rdat, r0);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, 12'h004, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        chk(rdat & 32'h40, 32'h0);
        $display("receive done");
        // Stored ack value is sent only by the ack sequence
        for (k = 0; k < 2; k++) begin
            n = nrise;
            apb(1'b1, 12'h000, 32'h8000 | (k << 5));
            repeat (20) @(posedge clk);
            chk(nrise, n);
            apb(1'b1, 12'h000, 32'h8010 | (k << 5));
            poll(12'h000, 4, 1'b0);
            chk({31'h0, cap[0]}, k);
        end
        apb(1'b1, 12'h000, 32'h8004);
        poll(12'h000, 2, 1'b0);
        chk(nsp, 1);
        apb(1'b0, 12'h004, 32'h0);
        chk(rdat & 32'h18, 32'h10);
        $display("ack and stop done");
        // Far side holds data low: collision, interrupt mask and clear
        apb(1'b1, 12'h000, 32'h8001);
        poll(12'h000, 0, 1'b0);
        ld(9'h000);
        apb(1'b1, 12'h008, 32'hFF);
        poll(12'h004, 10, 1'b1);
        apb(1'b0, 12'h000, 32'h0);
        chk(rdat & 32'h1F, 32'h0);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, 12'h014, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk((rdat & 32'h2) | irq, 32'h2);
        apb(1'b1, 12'h010, 32'h1F);
        apb(1'b1, 12'h014, 32'h1F);
        apb(1'b0, 12'h004, 32'h0);
        chk((rdat & 32'h400) | irq, 32'h400);
        apb(1'b1, 12'h004, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        chk(rdat & 32'h400, 32'h0);
        $display("collision done");
        report_and_stop();
    end
endmodule
`default_nettype wire
